// *** design/ebp_pin_mux.sv ***
// Purpose: shares external bus pins among static, sdram, nand and card paths
// Assumes: all inputs synchronous to sys_clk; controllers wait for their grant
// Notes: every pin is registered, so pins follow the owner one cycle later
module ebp_pin_mux (
  input wire logic sys_clk,
  input wire logic rst,
  // chip select assignment, bit i (1 to 5) switches region i to its alternate function, bit 0 is unused
  input wire logic [ebp_pkg::NUM_CS-1:0] cs_assign,
  // static memory controller side
  input wire logic st_req,
  output logic st_grant,
  input wire logic [ebp_pkg::ADDR_W-1:0] st_addr,
  input wire logic [ebp_pkg::NUM_CS-1:0] st_cs_n,
  input wire logic st_rd_n,
  input wire logic st_we0_n,
  input wire logic st_we1_n,
  input wire logic [ebp_pkg::DATA_W-1:0] st_wdata,
  input wire logic st_wdata_en,
  output logic st_wait_n,
  // sdram controller side
  input wire logic sd_req,
  output logic sd_grant,
  input wire logic sd_refresh,
  input wire logic [ebp_pkg::SD_ADDR_W-1:0] sd_addr,
  input wire logic [1:0] sd_bank,
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n,
  input wire logic sd_cke,
  input wire logic [1:0] sd_mask,
  input wire logic [ebp_pkg::DATA_W-1:0] sd_wdata,
  input wire logic sd_wdata_en,
  // card path side
  input wire logic card_ce_a_n,
  input wire logic card_ce_b_n,
  input wire logic card_rnw,
  input wire logic card_io_rd_n,
  // read data back to the controllers
  output logic [ebp_pkg::DATA_W-1:0] rd_data,
  // external pins
  output logic [ebp_pkg::ADDR_W-1:0] addr_pin,
  output logic [ebp_pkg::NUM_CS-1:0] chip_select_n,
  output logic static_read_n,
  output logic static_wr_en_low_n,
  output logic static_wr_en_high_n,
  input wire logic ext_wait_n,
  output logic sdram_clk_out,
  output logic sdram_clk_en,
  output logic sdram_write_en_n,
  output logic sdram_addr_10,
  output logic sdram_ras_n,
  output logic sdram_cas_n,
  output logic card_enable_a_n,
  output logic card_enable_b_n,
  output logic card_read_not_write,
  output logic nand_out_en_n,
  output logic nand_wr_en_n,
  input wire logic [ebp_pkg::DATA_W-1:0] data_in,
  output logic [ebp_pkg::DATA_W-1:0] data_out,
  output logic data_oe
);

  ebp_own_if own ();

  logic nand_region;
  logic card_region;
  logic sd_active;
  logic [ebp_pkg::ADDR_W-1:0] addr_q;
  logic [ebp_pkg::ADDR_W-1:0] addr_d;
  logic [ebp_pkg::NUM_CS-1:0] cs_n_q;
  logic [ebp_pkg::NUM_CS-1:0] cs_n_d;
  logic rd_n_q;
  logic we0_n_q;
  logic we1_q;
  logic [ebp_pkg::DATA_W-1:0] dout_q;
  logic doe_q;
  logic [ebp_pkg::DATA_W-1:0] rdata_q;
  logic wait_n_q;
  logic sdram_clk_out_q;

  // ----------------------------------------------------------------
  // ownership
  // ----------------------------------------------------------------
  assign own.st_req = st_req;
  assign own.sd_req = sd_req;
  assign own.sd_enabled = cs_assign[ebp_pkg::CS_SDRAM];

  ebp_owner_sel u_owner (
    .sys_clk(sys_clk),
    .rst(rst),
    .own(own)
  );

  assign st_grant = own.st_own;
  assign sd_grant = own.sd_own;

  // refresh uses only dedicated sdram pins, so it runs beside a static access
  assign sd_active = cs_assign[ebp_pkg::CS_SDRAM] && (own.sd_own || sd_refresh);

  // alternate regions are decoded from the live static selects
  assign nand_region = own.st_own &&
    (|(~st_cs_n[ebp_pkg::CS_NAND_HI:ebp_pkg::CS_NAND_LO] &
       cs_assign[ebp_pkg::CS_NAND_HI:ebp_pkg::CS_NAND_LO]));
  assign card_region = own.st_own &&
    (|(~st_cs_n[ebp_pkg::CS_CARD_HI:ebp_pkg::CS_CARD_LO] &
       cs_assign[ebp_pkg::CS_CARD_HI:ebp_pkg::CS_CARD_LO]));

  // ----------------------------------------------------------------
  // address pins
  // ----------------------------------------------------------------
  always_comb
  begin
    addr_d = addr_q;
    if (own.st_own)
      addr_d = st_addr;
    else if (own.sd_own)
    begin
      addr_d[0] = sd_mask[0];
      addr_d[11:2] = sd_addr[9:0];
      addr_d[14:13] = sd_addr[12:11];
      addr_d[16] = sd_bank[0];
      addr_d[17] = sd_bank[1];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      addr_q <= ebp_pkg::ADDR_RST;
    else
      addr_q <= addr_d;
  end

  // ----------------------------------------------------------------
  // chip selects
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ebp_pkg::NUM_CS; gi++)
    begin : g_cs
      if (gi == ebp_pkg::CS_SDRAM)
      begin : g_shared_sd
        always_comb
        begin
          if (cs_assign[gi])
            cs_n_d[gi] = sd_active ? sd_cs_n : 1'h1;
          else
            cs_n_d[gi] = own.st_own ? st_cs_n[gi] : 1'h1;
        end
      end
      else
      begin : g_static
        // regions 2..5 keep the static select in either function
        always_comb
        begin
          cs_n_d[gi] = own.st_own ? st_cs_n[gi] : 1'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cs_n_q <= ebp_pkg::CS_N_RST;
    else
      cs_n_q <= cs_n_d;
  end

  // ----------------------------------------------------------------
  // shared strobes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_n_q <= ebp_pkg::STROBE_N_RST;
      we0_n_q <= ebp_pkg::STROBE_N_RST;
      we1_q <= ebp_pkg::STROBE_N_RST;
    end
    else if (own.sd_own)
    begin
      rd_n_q <= 1'h1;
      we0_n_q <= 1'h1;
      we1_q <= sd_mask[1];
    end
    else if (nand_region)
    begin
      // nand uses its own strobes, shared ones stay idle
      rd_n_q <= 1'h1;
      we0_n_q <= 1'h1;
      we1_q <= 1'h1;
    end
    else if (own.st_own)
    begin
      rd_n_q <= st_rd_n;
      we0_n_q <= st_we0_n;
      we1_q <= card_region ? card_io_rd_n : st_we1_n;
    end
    else
    begin
      rd_n_q <= 1'h1;
      we0_n_q <= 1'h1;
      we1_q <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // dedicated nand and card pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      nand_out_en_n <= ebp_pkg::STROBE_N_RST;
      nand_wr_en_n <= ebp_pkg::STROBE_N_RST;
      card_enable_a_n <= ebp_pkg::STROBE_N_RST;
      card_enable_b_n <= ebp_pkg::STROBE_N_RST;
      card_read_not_write <= 1'h1;
    end
    else
    begin
      nand_out_en_n <= nand_region ? st_rd_n : 1'h1;
      nand_wr_en_n <= nand_region ? st_we0_n : 1'h1;
      card_enable_a_n <= card_region ? card_ce_a_n : 1'h1;
      card_enable_b_n <= card_region ? card_ce_b_n : 1'h1;
      card_read_not_write <= card_region ? card_rnw : 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // dedicated sdram pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sdram_ras_n <= ebp_pkg::STROBE_N_RST;
      sdram_cas_n <= ebp_pkg::STROBE_N_RST;
      sdram_write_en_n <= ebp_pkg::STROBE_N_RST;
      sdram_addr_10 <= 1'h0;
      sdram_clk_en <= ebp_pkg::SD_CKE_RST;
    end
    else
    begin
      // clock enable follows the controller even when idle, for self refresh
      sdram_clk_en <= sd_cke & cs_assign[ebp_pkg::CS_SDRAM];
      if (sd_active)
      begin
        sdram_ras_n <= sd_ras_n;
        sdram_cas_n <= sd_cas_n;
        sdram_write_en_n <= sd_we_n;
        sdram_addr_10 <= sd_addr[10];
      end
      else
      begin
        sdram_ras_n <= 1'h1;
        sdram_cas_n <= 1'h1;
        sdram_write_en_n <= 1'h1;
      end
    end
  end

  // divide by two: one toggle per system clock
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sdram_clk_out_q <= 1'h0;
    else if (cs_assign[ebp_pkg::CS_SDRAM])
      sdram_clk_out_q <= ~sdram_clk_out_q;
  end

  // ----------------------------------------------------------------
  // data bus and wait
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dout_q <= ebp_pkg::DATA_RST;
      doe_q <= 1'h0;
    end
    else if (own.st_own)
    begin
      dout_q <= st_wdata;
      doe_q <= st_wdata_en;
    end
    else if (own.sd_own)
    begin
      dout_q <= sd_wdata;
      doe_q <= sd_wdata_en;
    end
    else
      doe_q <= 1'h0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= ebp_pkg::DATA_RST;
      wait_n_q <= 1'h1;
    end
    else
    begin
      rdata_q <= data_in;
      wait_n_q <= ext_wait_n;
    end
  end

  assign addr_pin = addr_q;
  assign chip_select_n = cs_n_q;
  assign static_read_n = rd_n_q;
  assign static_wr_en_low_n = we0_n_q;
  assign static_wr_en_high_n = we1_q;
  assign sdram_clk_out = sdram_clk_out_q;
  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign rd_data = rdata_q;
  assign st_wait_n = wait_n_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_static_addr_only;
    own.sd_own |=> addr_pin[23:18] == $past(addr_pin[23:18]) && addr_pin[1] == $past(addr_pin[1]);
  endproperty
  a_static_addr_only: assert property (p_static_addr_only)
    else $error("static-only address pins changed during sdram access");

  property p_cs0_static;
    !own.st_own |=> chip_select_n[0];
  endproperty
  a_cs0_static: assert property (p_cs0_static)
    else $error("chip select 0 asserted without static ownership");

  property p_wait_pass;
    ##1 st_wait_n == $past(ext_wait_n);
  endproperty
  a_wait_pass: assert property (p_wait_pass)
    else $error("wait input not passed to static controller");

  property p_sdram_addr_map;
    own.sd_own |=> addr_pin[11:2] == $past(sd_addr[9:0]) && addr_pin[16] == $past(sd_bank[0])
      && addr_pin[17] == $past(sd_bank[1]) && addr_pin[14:13] == $past(sd_addr[12:11]);
  endproperty
  a_sdram_addr_map: assert property (p_sdram_addr_map)
    else $error("sdram address not mapped onto shared pins");

  property p_we1_mask;
    own.sd_own |=> static_wr_en_high_n == $past(sd_mask[1]) && addr_pin[0] == $past(sd_mask[0]);
  endproperty
  a_we1_mask: assert property (p_we1_mask)
    else $error("sdram masks not on shared pins");

  property p_cs1_static_mode;
    !cs_assign[1] |=> chip_select_n[1] == ($past(own.st_own) ? $past(st_cs_n[1]) : 1'h1);
  endproperty
  a_cs1_static_mode: assert property (p_cs1_static_mode)
    else $error("chip select 1 wrong in static use");

  property p_nand_strobes;
    nand_region |=> nand_out_en_n == $past(st_rd_n) && static_read_n;
  endproperty
  a_nand_strobes: assert property (p_nand_strobes)
    else $error("nand strobe not routed");

  property p_card_idle;
    !card_region |=> card_enable_a_n && card_enable_b_n;
  endproperty
  a_card_idle: assert property (p_card_idle)
    else $error("card enable asserted outside card region");

  property p_idle_hold;
    own.owner == ebp_pkg::EBP_OWN_IDLE ##1 own.owner == ebp_pkg::EBP_OWN_IDLE
      |=> $stable(addr_pin);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("address pins moved while idle");

  property p_data_release;
    !own.st_own && !own.sd_own |=> !data_oe;
  endproperty
  a_data_release: assert property (p_data_release)
    else $error("data bus driven with no owner");

  // static-only selects must be released whenever static does not own the pins
  property p_one_owner;
    !own.st_own |=> chip_select_n[0] && (&chip_select_n[5:2]);
  endproperty
  a_one_owner: assert property (p_one_owner)
    else $error("static chip select asserted without static ownership");

  c_sdram_access: cover property (own.sd_own ##1 !chip_select_n[1]);
  c_refresh_beside_static: cover property (own.st_own && sd_refresh && cs_assign[1]);
  c_card_access: cover property (card_region ##1 !card_enable_a_n);
  c_nand_write: cover property (nand_region ##1 !nand_wr_en_n);

endmodule // ebp_pin_mux

// *** inc/ebp_pkg.sv ***
// Purpose: shared constants and types of the external bus pin sharing layer
// Assumes: one 125 MHz system clock
// Notes: strobe and select idle levels are the reset values of the pin registers; address and data pins hold
package ebp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned NUM_CS = 6;
  localparam int unsigned SD_ADDR_W = 13;

  // ----------------------------------------------------------------
  // chip select positions
  // ----------------------------------------------------------------
  localparam int unsigned CS_STATIC_ONLY = 0;
  localparam int unsigned CS_SDRAM = 1;
  localparam int unsigned CS_NAND_LO = 2;
  localparam int unsigned CS_NAND_HI = 3;
  localparam int unsigned CS_CARD_LO = 4;
  localparam int unsigned CS_CARD_HI = 5;

  // ----------------------------------------------------------------
  // reset values of the pins
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [NUM_CS-1:0] CS_N_RST = 6'h3F;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic STROBE_N_RST = 1'h1;
  localparam logic SD_CKE_RST = 1'h0;

  // ----------------------------------------------------------------
  // timing: sdram clock is the system clock divided by this
  // ----------------------------------------------------------------
  localparam int unsigned SDRAM_CLK_OUT_DIV = 2;

  // ----------------------------------------------------------------
  // owner of the shared pins
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EBP_OWN_IDLE = 3'h1,
    EBP_OWN_STATIC = 3'h2,
    EBP_OWN_SDRAM = 3'h4
  } ebp_owner_t;

endpackage

// *** inc/ebp_own_if.sv ***
// Purpose: request and ownership signals between pin mux and owner select
// Assumes: single clock domain
// Notes: own flags come straight from the owner state register
interface ebp_own_if;
  logic st_req;
  logic sd_req;
  logic sd_enabled;
  logic st_own;
  logic sd_own;
  ebp_pkg::ebp_owner_t owner;

  modport sel (
    input st_req,
    input sd_req,
    input sd_enabled,
    output st_own,
    output sd_own,
    output owner
  );

  modport mux (
    output st_req,
    output sd_req,
    output sd_enabled,
    input st_own,
    input sd_own,
    input owner
  );
endinterface

// *** design/ebp_owner_sel.sv ***
// Purpose: decides which controller owns the shared pins
// Assumes: a controller holds its request for the whole access
// Notes: static wins a simultaneous request; ownership lasts until request drops, or for sdram until its region is reassigned
module ebp_owner_sel (
  input wire logic sys_clk,
  input wire logic rst,
  ebp_own_if.sel own
);

  ebp_pkg::ebp_owner_t state_q;
  ebp_pkg::ebp_owner_t state_d;

  // ----------------------------------------------------------------
  // next owner
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ebp_pkg::EBP_OWN_IDLE:
      begin
        if (own.st_req)
          state_d = ebp_pkg::EBP_OWN_STATIC;
        else if (own.sd_req && own.sd_enabled)
          state_d = ebp_pkg::EBP_OWN_SDRAM;
      end
      ebp_pkg::EBP_OWN_STATIC:
      begin
        if (!own.st_req)
          state_d = ebp_pkg::EBP_OWN_IDLE;
      end
      ebp_pkg::EBP_OWN_SDRAM:
      begin
        // sdram is dropped at once if its region is reassigned
        if (!own.sd_req || !own.sd_enabled)
          state_d = ebp_pkg::EBP_OWN_IDLE;
      end
      default:
        state_d = ebp_pkg::EBP_OWN_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_q <= ebp_pkg::EBP_OWN_IDLE;
    else
      state_q <= state_d;
  end

  assign own.owner = state_q;
  assign own.st_own = (state_q == ebp_pkg::EBP_OWN_STATIC);
  assign own.sd_own = (state_q == ebp_pkg::EBP_OWN_SDRAM);

endmodule // ebp_owner_sel

// *** dv/ebp_ext_mem.sv ***
// Purpose: external memory and wait source facing the shared pins
// Assumes: pins change only on sys_clk edges
// Notes: released read data shows the inverse of its last value
module ebp_ext_mem (
  input wire logic sys_clk,
  input wire logic [ebp_pkg::ADDR_W-1:0] addr_pin,
  input wire logic [ebp_pkg::NUM_CS-1:0] chip_select_n,
  input wire logic static_read_n,
  input wire logic static_wr_en_low_n,
  input wire logic [ebp_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic hold_wait,
  output logic [ebp_pkg::DATA_W-1:0] data_in,
  output logic ext_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [ebp_pkg::DATA_W-1:0] mem_q [16];
  logic [ebp_pkg::DATA_W-1:0] last_q = 16'h0000;
  logic sel;
  assign sel = ~&chip_select_n;
  always @(posedge sys_clk)
    if (sel && !static_wr_en_low_n && data_oe)
      mem_q[addr_pin[4:1]] <= data_out;
  // a floating bus must not look like valid data
  assign data_in = (sel && !static_read_n) ? mem_q[addr_pin[4:1]] : ~last_q;
  always @(posedge sys_clk)
    last_q <= data_in;
  // device stretches the access, active low
  assign ext_wait_n = ~hold_wait;
endmodule // ebp_ext_mem

// *** dv/testbench.sv ***
// Purpose: self-checking bench of the shared pin layer
// Assumes: pins assigned and clocks enabled before the first access
// Notes: inputs move 1 ns after the rising edge
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'h0, rst = 1'h1;
  logic [ebp_pkg::NUM_CS-1:0] cs_assign = 6'h00, st_cs_n = 6'h3F, chip_select_n;
  logic [ebp_pkg::ADDR_W-1:0] st_addr = 24'h000000, addr_pin;
  logic [ebp_pkg::DATA_W-1:0] st_wdata = 16'h0000, sd_wdata = 16'h0000;
  logic [ebp_pkg::DATA_W-1:0] rd_data, data_in, data_out;
  logic [ebp_pkg::SD_ADDR_W-1:0] sd_addr = 13'h0000;
  logic [1:0] sd_bank = 2'h0, sd_mask = 2'h0;
  logic st_req = 1'h0, st_rd_n = 1'h1, st_we0_n = 1'h1, st_we1_n = 1'h1, st_wdata_en = 1'h0;
  logic sd_req = 1'h0, sd_refresh = 1'h0, sd_cs_n = 1'h1, sd_ras_n = 1'h1, sd_cas_n = 1'h1;
  logic sd_we_n = 1'h1, sd_cke = 1'h0, sd_wdata_en = 1'h0, hold_wait = 1'h0;
  logic card_ce_a_n = 1'h1, card_ce_b_n = 1'h1, card_rnw = 1'h1, card_io_rd_n = 1'h1;
  logic st_grant, sd_grant, st_wait_n, static_read_n, static_wr_en_low_n, static_wr_en_high_n;
  logic ext_wait_n, sdram_clk_out, sdram_clk_en, sdram_write_en_n, sdram_addr_10;
  logic sdram_ras_n, sdram_cas_n, card_enable_a_n, card_enable_b_n, card_read_not_write;
  logic nand_out_en_n, nand_wr_en_n, data_oe;
  int num_errors = 0, checked = 0;
  always #4 sys_clk = ~sys_clk;
  ebp_pin_mux dut_u (.sys_clk, .rst, .cs_assign, .st_req, .st_grant, .st_addr, .st_cs_n,
    .st_rd_n, .st_we0_n, .st_we1_n, .st_wdata, .st_wdata_en, .st_wait_n, .sd_req, .sd_grant,
    .sd_refresh, .sd_addr, .sd_bank, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_cke,
    .sd_mask, .sd_wdata, .sd_wdata_en, .card_ce_a_n, .card_ce_b_n, .card_rnw, .card_io_rd_n,
    .rd_data, .addr_pin, .chip_select_n, .static_read_n, .static_wr_en_low_n,
    .static_wr_en_high_n, .ext_wait_n, .sdram_clk_out, .sdram_clk_en, .sdram_write_en_n,
    .sdram_addr_10, .sdram_ras_n, .sdram_cas_n, .card_enable_a_n, .card_enable_b_n,
    .card_read_not_write, .nand_out_en_n, .nand_wr_en_n, .data_in, .data_out, .data_oe);
  ebp_ext_mem mem_u (.sys_clk, .addr_pin, .chip_select_n, .static_read_n,
    .static_wr_en_low_n, .data_out, .data_oe, .hold_wait, .data_in, .ext_wait_n);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task complete_run;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // grant comes one cycle after the request, pins one cycle after the grant
  task get_pins(input logic sd);
    int i;
    i = 0;
    while ((sd ? sd_grant : st_grant) !== 1'h1 && i < 20)
    begin
      tick(1);
      i++;
    end
    if (i == 20)
    begin
      num_errors++;
      complete_run;
    end
    tick(1);
  endtask
  task drop;
    {st_req, sd_req, sd_refresh, st_wdata_en, sd_wdata_en} = 5'h00;
    {st_rd_n, st_we0_n, st_we1_n} = 3'h7;
    tick(3);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_static;
    st_addr = 24'hFC9002;
    st_cs_n = 6'h3E;
    {st_we0_n, st_wdata_en, st_req, sd_req} = 4'h7;
    st_wdata = 16'hA55A;
    get_pins(1'h0);
    chk(addr_pin, 24'hFC9002);
    chk(chip_select_n, 6'h3E);
    chk(static_wr_en_low_n, 1'h0);
    chk({data_oe, data_out}, 17'h1A55A);
    chk(sd_grant, 1'h0);
    chk(sdram_ras_n, 1'h1);
    {st_we0_n, st_wdata_en, st_rd_n} = 3'h4;
    tick(1);
    chk({data_oe, static_read_n}, 2'h0);
    tick(1);
    chk(rd_data, 16'hA55A);
    drop;
    chk({chip_select_n, static_read_n, data_oe}, 8'hFE);
    st_addr = 24'h000000;
    tick(2);
    chk(addr_pin, 24'hFC9002);
  endtask
  task t_sdram;
    logic c;
    cs_assign = 6'h02;
    sd_addr = 13'h1EBC;
    {sd_bank, sd_mask, sd_wdata} = {2'h2, 2'h1, 16'h1234};
    {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_cke, sd_wdata_en} = 6'h0B;
    {st_req, sd_req} = 2'h3;
    get_pins(1'h0);
    chk(sd_grant, 1'h0);
    st_req = 1'h0;
    get_pins(1'h1);
    chk(addr_pin[0], sd_mask[0]);
    chk(addr_pin[11:2], sd_addr[9:0]);
    chk(addr_pin[14:13], sd_addr[12:11]);
    chk(addr_pin[16], sd_bank[0]);
    chk(addr_pin[17], sd_bank[1]);
    chk(chip_select_n[1], 1'h0);
    chk(static_wr_en_high_n, sd_mask[1]);
    chk({sdram_clk_en, sdram_write_en_n, sdram_addr_10, sdram_ras_n, sdram_cas_n}, 5'h15);
    chk({data_oe, data_out, static_read_n}, 18'h22469);
    // invert here: inverting inside the call would widen to 32 bits first
    c = ~sdram_clk_out;
    tick(1);
    chk(sdram_clk_out, c);
    drop;
    {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_cke} = 5'h1E;
    tick(1);
    chk(chip_select_n[1], 1'h1);
  endtask
  task t_nand;
    for (int k = 2; k < 4; k++)
    begin
      cs_assign = 6'h01 << k;
      st_cs_n = ~(6'h01 << k);
      {st_rd_n, st_req} = 2'h1;
      get_pins(1'h0);
      chk(chip_select_n[k], 1'h0);
      chk({nand_out_en_n, nand_wr_en_n, static_read_n}, 3'h3);
      {st_rd_n, st_we0_n} = 2'h2;
      tick(1);
      chk({nand_wr_en_n, static_wr_en_low_n}, 2'h1);
      cs_assign = 6'h00;
      tick(1);
      chk({nand_wr_en_n, static_wr_en_low_n}, 2'h2);
      drop;
    end
  endtask
  task t_card;
    for (int k = 4; k < 6; k++)
    begin
      cs_assign = 6'h01 << k;
      st_cs_n = ~(6'h01 << k);
      {st_rd_n, card_ce_a_n, card_ce_b_n, card_rnw, card_io_rd_n, st_req} = 6'h0D;
      get_pins(1'h0);
      chk(chip_select_n[k], 1'h0);
      chk(static_read_n, 1'h0);
      chk({card_enable_a_n, card_enable_b_n, card_read_not_write}, 3'h3);
      chk(static_wr_en_high_n, 1'h0);
      {st_rd_n, st_we0_n, card_ce_a_n, card_ce_b_n, card_rnw} = 5'h14;
      tick(1);
      chk(static_wr_en_low_n, 1'h0);
      chk({card_enable_a_n, card_enable_b_n, card_read_not_write}, 3'h4);
      {card_ce_a_n, card_ce_b_n, card_rnw, card_io_rd_n} = 4'hF;
      drop;
    end
  endtask
  task t_refresh;
    cs_assign = 6'h02;
    st_addr = 24'h123456;
    st_cs_n = 6'h3E;
    {st_rd_n, st_req} = 2'h1;
    get_pins(1'h0);
    {sd_refresh, sd_cs_n, sd_ras_n, sd_cas_n} = 4'h8;
    tick(1);
    chk({chip_select_n[1], sdram_ras_n, sdram_cas_n}, 3'h0);
    chk({addr_pin, static_read_n, st_grant}, 26'h048D159);
    {sd_cs_n, sd_ras_n, sd_cas_n} = 3'h7;
    drop;
  endtask
  task t_wait;
    hold_wait = 1'h1;
    tick(1);
    chk(st_wait_n, 1'h0);
    hold_wait = 1'h0;
    tick(1);
    chk(st_wait_n, 1'h1);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    // io routing and clocks are taken as set up from the start
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'h0;
    tick(1);
    chk(addr_pin, ebp_pkg::ADDR_RST);
    chk(chip_select_n, ebp_pkg::CS_N_RST);
    chk({data_oe, st_grant, sdram_clk_en}, 3'h0);
    t_static;
    t_sdram;
    t_nand;
    t_card;
    t_refresh;
    t_wait;
    // all traffic stops before the run ends
    chk({chip_select_n, data_oe, st_grant, sd_grant}, 9'h1F8);
    complete_run;
  end
endmodule // testbench
